// [hw/cfog_pkg.sv]
// Constants, field layouts and carrier types of the clock fan-out gating
// block; shared by the top module and the SMBus target.
package cfog_pkg;

  // Structure
  localparam int CFOG_NUM_OUT = 2;

  // SMBus target address, seven bits without the read/write bit
  localparam logic [6:0] CFOG_SMB_ADDR = 7'h6D;

  // Byte indices of the configuration bytes
  localparam logic [7:0] CFOG_IDX_ENABLE = 8'h00;
  localparam logic [7:0] CFOG_IDX_MODE = 8'h01;
  localparam logic [7:0] CFOG_IDX_SLEW = 8'h02;

  // Field positions in config byte one
  localparam int CFOG_MODE_RB_LSB = 6;
  localparam int CFOG_MODE_CTL_LSB = 3;
  localparam int CFOG_AMP_LSB = 0;

  // PLL mode encoding, shared by readback and control fields
  typedef enum logic [1:0] {
    CFOG_MODE_LOBW = 2'h0,
    CFOG_MODE_BYP = 2'h1,
    CFOG_MODE_HIBW = 2'h3
  } cfog_mode_t;

  // Reset values: every output enabled, so no SMBus access is needed
  localparam logic [1:0] CFOG_OE_RST = 2'h3;
  localparam logic [1:0] CFOG_AMP_RST = 2'h2;
  localparam logic [1:0] CFOG_SLEW_RST = 2'h3;
  localparam cfog_mode_t CFOG_MODE_RST = CFOG_MODE_LOBW;

  // Output drive deadline after power-good rises
  localparam int CFOG_CLK_HZ = 25_000_000;
  localparam int CFOG_T_DRV_US = 300;
  localparam int CFOG_DRV_CYC = CFOG_T_DRV_US * (CFOG_CLK_HZ / 1_000_000);

  typedef struct packed {
    logic [1:0] oe_bits;
    cfog_mode_t mode_ctl;
    logic [1:0] amp;
    logic [1:0] slew;
  } cfog_cfg_t;

  // Events from the SMBus target to the configuration bytes
  typedef struct packed {
    logic idx_set;
    logic wr;
    logic rd_adv;
    logic [7:0] data;
  } cfog_smb_ev_t;

endpackage

// [hw/cfog_sync.sv]
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
module cfog_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// [hw/cfog_smb_target.sv]
// SMBus target: address match, command byte, byte writes, byte reads.
// Assumes synchronised bus levels on the local clock, oversampled.
`timescale 1ns/1ps
module cfog_smb_target
  import cfog_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Synchronised bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Open-drain data drive, high while pulling low
  output logic sda_oe_o,
  // Register side
  input wire logic [7:0] rd_data_i,
  output cfog_smb_ev_t ev_o
);
  typedef enum logic [2:0] {
    SMB_IDLE, SMB_ADDR, SMB_CMD, SMB_WDATA,
    SMB_ACK, SMB_HOLD, SMB_RDATA, SMB_RACK
  } cfog_smb_st_t;

  typedef struct packed {
    cfog_smb_st_t st;
    cfog_smb_st_t after;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic oe;
    logic scl_d;
    logic sda_d;
    cfog_smb_ev_t ev;
  } cfog_smb_t;

  cfog_smb_t r, s;
  logic rise, fall, start, stop;
  logic [7:0] byte_in;

  assign rise = scl_i && !r.scl_d;
  assign fall = !scl_i && r.scl_d;
  assign start = scl_i && r.scl_d && r.sda_d && !sda_i;
  assign stop = scl_i && r.scl_d && !r.sda_d && sda_i;
  assign byte_in = {r.sh[6:0], sda_i};

  always_comb begin
    s = r;
    s.scl_d = scl_i;
    s.sda_d = sda_i;
    s.ev.idx_set = 1'b0;
    s.ev.wr = 1'b0;
    s.ev.rd_adv = 1'b0;
    if (start) begin
      s.st = SMB_ADDR;
      s.cnt = 3'h0;
      s.oe = 1'b0;
    end else if (stop) begin
      s.st = SMB_IDLE;
      s.oe = 1'b0;
    end else if (rise) begin
      case (r.st)
        SMB_ADDR, SMB_CMD, SMB_WDATA: begin
          s.sh = byte_in;
          s.cnt = r.cnt + 3'h1;
          if (r.cnt == 3'h7) begin
            s.st = SMB_ACK;
            s.ev.data = byte_in;
            if (r.st == SMB_ADDR) begin
              if (byte_in[7:1] != CFOG_SMB_ADDR) begin
                s.st = SMB_IDLE;
              end
              s.after = byte_in[0] ? SMB_RDATA : SMB_CMD;
            end else begin
              s.after = SMB_WDATA;
              s.ev.idx_set = (r.st == SMB_CMD);
              s.ev.wr = (r.st == SMB_WDATA);
            end
          end
        end
        SMB_RDATA: begin
          s.cnt = r.cnt + 3'h1;
          if (r.cnt == 3'h7) begin
            s.st = SMB_RACK;
          end
        end
        SMB_RACK: begin
          s.st = sda_i ? SMB_IDLE : SMB_HOLD;
          s.after = SMB_RDATA;
          s.ev.rd_adv = !sda_i;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (r.st)
        SMB_ACK: begin
          s.oe = 1'b1;
          s.st = SMB_HOLD;
        end
        SMB_HOLD: begin
          s.st = r.after;
          s.cnt = 3'h0;
          s.oe = 1'b0;
          if (r.after == SMB_RDATA) begin
            s.sh = rd_data_i;
            s.oe = !rd_data_i[7];
          end
        end
        SMB_RDATA: begin
          s.sh = {r.sh[6:0], 1'b0};
          s.oe = !r.sh[6];
        end
        SMB_RACK: begin
          s.oe = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{st: SMB_IDLE, after: SMB_IDLE, scl_d: 1'b1, sda_d: 1'b1,
             default: '0};
    end else begin
      r <= s;
    end
  end

  assign sda_oe_o = r.oe;
  assign ev_o = r.ev;

  property p_addr_miss;
    @(posedge clk_i) disable iff (!rst_b_i)
    (rise && !start && !stop && r.st == SMB_ADDR && r.cnt == 3'h7 &&
     byte_in[7:1] != CFOG_SMB_ADDR) |=> (r.st == SMB_IDLE) && !r.oe;
  endproperty
  chk_addr_miss_ignored: assert property (p_addr_miss)
    else $error("target answered a foreign address");
endmodule

// [hw/cfog_top.sv]
// Output gating and mode control of a two-output clock fan-out buffer.
// Assumes a free-running local clock, a reference clock that may stop
// in power-down, and pins that are asynchronous to both clocks.
`timescale 1ns/1ps
module cfog_top
  import cfog_pkg::*;
#(
  parameter int N = CFOG_NUM_OUT,
  parameter int unsigned DRV_TIMEOUT_CYC = CFOG_DRV_CYC
) (
  // Local clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Reference clock of the outputs
  input wire logic ref_clk_i,
  // Board control pins
  input wire logic power_good_powerdown_n_i,
  input wire logic [1:0] pll_mode_select_trilevel_i,
  input wire logic [N-1:0] output_enable_pin_n_i,
  // PLL
  input wire logic pll_lock_i,
  output logic pll_enable_o,
  output logic pll_high_bw_o,
  // SMBus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Output pairs and analog settings
  output logic [N-1:0] clock_output_pair_p_o,
  output logic [N-1:0] clock_output_pair_n_o,
  output logic [N-1:0] slew_fast_o,
  output logic [1:0] amplitude_o
);
  typedef enum logic [1:0] {PWR_OFF, PWR_WAIT, PWR_RUN} cfog_pwr_st_t;

  typedef struct packed {
    cfog_pwr_st_t st;
    logic latched;
    cfog_mode_t mode_lat;
    cfog_cfg_t cfg;
    logic [7:0] idx;
    logic [15:0] wait_cnt;
    logic pll_en;
    logic run;
  } cfog_ctl_t;

  typedef struct packed {
    logic [N-1:0] act;
    logic [N-1:0] tru;
    logic [N-1:0] cmp;
  } cfog_leg_t;

  localparam logic [15:0] DRV_LAST = 16'(DRV_TIMEOUT_CYC - 1);

  cfog_ctl_t r, s;
  cfog_leg_t l_r, l_s;
  cfog_smb_ev_t ev;
  logic pg_s, lock_s, scl_s, sda_s;
  logic [1:0] strap_s;
  logic [7:0] rd_data;
  logic run_x;
  logic [N-1:0] en_x, pin_x, en_req;

  // Pins into the local domain
  cfog_sync #(.W(6)) u_sync_loc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({power_good_powerdown_n_i, pll_lock_i, scl_i, sda_i,
          pll_mode_select_trilevel_i}),
    .q_o({pg_s, lock_s, scl_s, sda_s, strap_s})
  );

  cfog_smb_target u_smb (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .sda_oe_o(sda_oe_o),
    .rd_data_i(rd_data),
    .ev_o(ev)
  );

  assign sda_o = 1'b0;

  // Mid level of the strap shows up as code 01 from the pin comparators
  function automatic cfog_mode_t strap_decode(input logic [1:0] code);
    cfog_mode_t m;
    m = CFOG_MODE_HIBW;
    if (code == 2'h0) begin
      m = CFOG_MODE_LOBW;
    end else if (code == 2'h1) begin
      m = CFOG_MODE_BYP;
    end
    return m;
  endfunction

  // Readback of the configuration bytes
  always_comb begin
    rd_data = 8'h00;
    case (r.idx)
      CFOG_IDX_ENABLE: rd_data[N-1:0] = r.cfg.oe_bits;
      CFOG_IDX_MODE: begin
        rd_data[CFOG_MODE_RB_LSB +: 2] = r.mode_lat;
        rd_data[CFOG_MODE_CTL_LSB +: 2] = r.cfg.mode_ctl;
        rd_data[CFOG_AMP_LSB +: 2] = r.cfg.amp;
      end
      CFOG_IDX_SLEW: rd_data[N-1:0] = r.cfg.slew;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    s = r;
    if (ev.idx_set) begin
      s.idx = ev.data;
    end
    if (ev.wr || ev.rd_adv) begin
      s.idx = r.idx + 8'h01;
    end
    if (ev.wr) begin
      case (r.idx)
        CFOG_IDX_ENABLE: s.cfg.oe_bits = ev.data[N-1:0];
        CFOG_IDX_MODE: begin
          s.cfg.mode_ctl = cfog_mode_t'(ev.data[CFOG_MODE_CTL_LSB +: 2]);
          s.cfg.amp = ev.data[CFOG_AMP_LSB +: 2];
        end
        CFOG_IDX_SLEW: s.cfg.slew = ev.data[N-1:0];
        default: begin
        end
      endcase
    end
    case (r.st)
      PWR_OFF: begin
        s.wait_cnt = 16'h0000;
        if (pg_s) begin
          s.st = PWR_WAIT;
          if (!r.latched) begin
            // Strap capture outranks a same-cycle host write
            s.latched = 1'b1;
            s.mode_lat = strap_decode(strap_s);
            s.cfg.mode_ctl = strap_decode(strap_s);
          end
        end
      end
      PWR_WAIT: begin
        s.wait_cnt = r.wait_cnt + 16'h0001;
        if (!pg_s) begin
          s.st = PWR_OFF;
        end else if (lock_s || r.cfg.mode_ctl == CFOG_MODE_BYP) begin
          s.st = PWR_RUN;
        end else if (r.wait_cnt >= DRV_LAST) begin
          // A PLL that never locks must not hold the outputs forever
          s.st = PWR_RUN;
        end
      end
      PWR_RUN: begin
        if (!pg_s) begin
          s.st = PWR_OFF;
        end
      end
      default: s.st = PWR_OFF;
    endcase
    s.pll_en = (s.st != PWR_OFF) && (s.cfg.mode_ctl != CFOG_MODE_BYP);
    s.run = (s.st == PWR_RUN) && pg_s;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{st: PWR_OFF, mode_lat: CFOG_MODE_RST,
             cfg: '{oe_bits: CFOG_OE_RST, mode_ctl: CFOG_MODE_RST,
                    amp: CFOG_AMP_RST, slew: CFOG_SLEW_RST},
             default: '0};
    end else begin
      r <= s;
    end
  end

  assign pll_enable_o = r.pll_en;
  assign pll_high_bw_o = (r.cfg.mode_ctl == CFOG_MODE_HIBW);
  assign slew_fast_o = r.cfg.slew;
  assign amplitude_o = r.cfg.amp;

  // Run level, enable bits and pins into the reference domain
  cfog_sync #(.W(1 + 2 * N)) u_sync_ref (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({r.run, r.cfg.oe_bits, output_enable_pin_n_i}),
    .q_o({run_x, en_x, pin_x})
  );

  assign en_req = {N{run_x}} & en_x & ~pin_x;

  // Each pair toggles at half the reference rate; a stop is taken only
  // with the true leg low, so neither leg shows a short pulse at a stop.
  always_comb begin
    l_s = l_r;
    for (int i = 0; i < N; i++) begin
      if (l_r.act[i] && l_r.tru[i]) begin
        l_s.tru[i] = 1'b0;
        l_s.cmp[i] = 1'b1;
      end else if (en_req[i]) begin
        l_s.act[i] = 1'b1;
        l_s.tru[i] = 1'b1;
        l_s.cmp[i] = 1'b0;
      end else begin
        l_s.act[i] = 1'b0;
        l_s.tru[i] = 1'b0;
        l_s.cmp[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l_r <= '0;
    end else begin
      l_r <= l_s;
    end
  end

  // The reference clock may stop in power-down, so the legs are also
  // forced low from the local domain; this gate can only pull low.
  assign clock_output_pair_p_o = l_r.tru & {N{r.st != PWR_OFF}};
  assign clock_output_pair_n_o = l_r.cmp & {N{r.st != PWR_OFF}};

  property p_pd_off;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pg_s |=> !pll_enable_o && !r.run;
  endproperty
  chk_pd_pll_off: assert property (p_pd_off)
    else $error("PLL or run left on in power-down");

  property p_first_latch;
    @(posedge clk_i) disable iff (!rst_b_i)
    (r.st == PWR_OFF && pg_s && !r.latched) |=>
      r.latched && r.mode_lat == strap_decode($past(strap_s));
  endproperty
  chk_strap_first_latch: assert property (p_first_latch)
    else $error("strap not captured at first power-good");

  property p_resume;
    @(posedge clk_i) disable iff (!rst_b_i)
    (r.st == PWR_OFF && pg_s && r.latched) |=>
      r.st == PWR_WAIT && $stable(r.mode_lat);
  endproperty
  chk_pd_exit_resume: assert property (p_resume)
    else $error("power-down not left or strap re-sampled");

  property p_bypass;
    @(posedge clk_i) disable iff (!rst_b_i)
    (r.cfg.mode_ctl == CFOG_MODE_BYP) |-> !pll_enable_o;
  endproperty
  chk_bypass_pll_off: assert property (p_bypass)
    else $error("PLL enabled in bypass");

  property p_mode_write;
    @(posedge clk_i) disable iff (!rst_b_i)
    (ev.wr && r.idx == CFOG_IDX_MODE && !(r.st == PWR_OFF && pg_s &&
     !r.latched)) |=> r.cfg.mode_ctl == $past(ev.data[4:3]);
  endproperty
  chk_mode_ctl_write: assert property (p_mode_write)
    else $error("mode control write lost");

  sequence s_unlocked_wait;
    r.st == PWR_WAIT && !lock_s && r.cfg.mode_ctl != CFOG_MODE_BYP &&
      r.wait_cnt < DRV_LAST;
  endsequence
  property p_lock_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_unlocked_wait |=> !r.run;
  endproperty
  chk_lock_gate_run: assert property (p_lock_gate)
    else $error("outputs released before lock");

  property p_drv_bound;
    @(posedge clk_i) disable iff (!rst_b_i)
    r.st == PWR_WAIT |-> r.wait_cnt <= DRV_LAST;
  endproperty
  chk_drive_deadline: assert property (p_drv_bound)
    else $error("release deadline exceeded");

  property p_oe_write;
    @(posedge clk_i) disable iff (!rst_b_i)
    (ev.wr && r.idx == CFOG_IDX_ENABLE) |=>
      r.cfg.oe_bits == $past(ev.data[N-1:0]);
  endproperty
  chk_oe_bit_write: assert property (p_oe_write)
    else $error("output enable write lost");

  property p_ctl_copy;
    @(posedge clk_i) disable iff (!rst_b_i)
    (r.st == PWR_OFF && pg_s && !r.latched) |=>
      r.cfg.mode_ctl == r.mode_lat;
  endproperty
  chk_mode_ctl_copy: assert property (p_ctl_copy)
    else $error("mode control not loaded from strap");

  // Legs are gated from the local domain, so a stopped reference
  // clock cannot leave a leg high in power-down
  property p_pd_legs;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pg_s [*2] |-> clock_output_pair_p_o == '0 &&
      clock_output_pair_n_o == '0;
  endproperty
  chk_pd_legs_low: assert property (p_pd_legs)
    else $error("pair leg high in power-down");

  for (genvar g = 0; g < N; g++) begin : g_chk
    sequence s_req_rise;
      $rose(en_req[g]);
    endsequence
    property p_start;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_req_rise |-> ##[1:3] clock_output_pair_p_o[g] || !en_req[g] ||
        r.st == PWR_OFF;
    endproperty
    chk_pair_start_latency: assert property (p_start)
      else $error("pair did not start in time");

    property p_stop;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !en_req[g] [*3] |-> !l_r.tru[g] && !l_r.cmp[g];
    endproperty
    chk_pair_held_low: assert property (p_stop)
      else $error("disabled pair still toggling");

    property p_clean_stop;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $fell(l_r.act[g]) |-> !$past(l_r.tru[g]);
    endproperty
    chk_stop_leg_low: assert property (p_clean_stop)
      else $error("pair stopped with true leg high");
  end
endmodule

// [bench/cfog_host_model.sv]
// Far-side model: SMBus host on open-drain wires and the board PLL lock.
// Assumes the bench resolves SDA and calls the tasks after a clk_i edge.
`timescale 1ns/1ps
module cfog_host_model
  import cfog_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // SMBus, resolved SDA level in, host drives out
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  // PLL
  input wire logic pll_enable_i,
  output logic pll_lock_o
);
  int lock_cyc = 40;
  int cnt = 0;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    pll_lock_o = 1'b0;
  end

  // Lock is lost at once when the PLL is switched off
  always @(posedge clk_i) begin
    if (!pll_enable_i) begin
      cnt <= 0;
      pll_lock_o <= 1'b0;
    end else if (cnt >= lock_cyc) begin
      pll_lock_o <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Quarter of an SCL period: 16 local clocks a bit keeps oversampling safe
  task automatic qtr();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // Start: SDA falls while SCL is high; stop: SDA rises while SCL is high
  task automatic edge_cond(input logic stop);
    sda_low_o = stop;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = !stop;
    qtr();
    if (!stop) begin
      scl_o = 1'b0;
      qtr();
    end
  endtask

  // Drives b (1 releases) and samples the wire while SCL is high
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = !b;
    qtr();
    scl_o = 1'b1;
    qtr();
    s = sda_i;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
  endtask

  // Address, index, one data byte; ack_n is high if any byte went unacked
  task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                    input logic [7:0] d, output logic ack_n);
    logic [7:0] q;
    logic s0;
    logic s1;
    logic s2;
    edge_cond(1'b0);
    byte_io({a, 1'b0}, q);
    bit_io(1'b1, s0);
    byte_io(idx, q);
    bit_io(1'b1, s1);
    byte_io(d, q);
    bit_io(1'b1, s2);
    edge_cond(1'b1);
    ack_n = s0 | s1 | s2;
  endtask

  // Sets the index, then reads one byte and ends it with a NACK
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic [7:0] q;
    logic s;
    edge_cond(1'b0);
    byte_io({CFOG_SMB_ADDR, 1'b0}, q);
    bit_io(1'b1, s);
    byte_io(idx, q);
    bit_io(1'b1, s);
    edge_cond(1'b1);
    edge_cond(1'b0);
    byte_io({CFOG_SMB_ADDR, 1'b1}, q);
    bit_io(1'b1, s);
    byte_io(8'hFF, d);
    bit_io(1'b1, s);
    edge_cond(1'b1);
  endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the clock fan-out gating block.
// Assumes the host model in cfog_host_model and a short drive timeout.
`timescale 1ns/1ps
module tb_top;
  import cfog_pkg::*;
  localparam int TMO = 150;
  localparam logic [1:0] STRAP [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  localparam logic [1:0] MODE [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
  // SMBus enable bits, pin levels, pairs expected to run
  localparam logic [5:0] ROWS [5] = '{6'h33, 6'h36, 6'h11, 6'h28, 6'h26};
  localparam logic [7:0] MDATA [3] = '{8'h19, 8'h0A, 8'h02};

  logic clk = 1'b0;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pg = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [1:0] pin_n = 2'h0;
  logic pll_lock;
  logic pll_en;
  logic high_bw;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic host_low;
  logic [1:0] dp;
  logic [1:0] dn;
  logic [1:0] slew;
  logic [1:0] amp;
  logic [7:0] d;
  logic a;
  int n_fail = 0;
  int comparisons = 0;

  assign sda = ~(host_low | (sda_oe & ~sda_out));

  initial begin
    forever #20 clk = ~clk;
  end
  // Reference keeps running so the output pairs can toggle; the SMBus side runs on clk
  initial begin
    #13;
    forever #40 ref_clk = ~ref_clk;
  end

  cfog_top #(.DRV_TIMEOUT_CYC(TMO)) dut (
    .clk_i(clk), .rst_b_i(rst_b), .ref_clk_i(ref_clk),
    .power_good_powerdown_n_i(pg), .pll_mode_select_trilevel_i(strap),
    .output_enable_pin_n_i(pin_n), .pll_lock_i(pll_lock),
    .pll_enable_o(pll_en), .pll_high_bw_o(high_bw), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .clock_output_pair_p_o(dp), .clock_output_pair_n_o(dn),
    .slew_fast_o(slew), .amplitude_o(amp)
  );

  cfog_host_model host (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low),
    .pll_enable_i(pll_en), .pll_lock_o(pll_lock)
  );

  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Running pair toggles with n = ~p; a stopped pair keeps both legs low
  task automatic obs(input logic [1:0] exp);
    logic [1:0] hi;
    logic [1:0] lo;
    logic [1:0] bad;
    hi = 2'h0;
    lo = 2'h0;
    bad = 2'h0;
    repeat (16) begin
      @(negedge ref_clk);
      hi |= dp;
      lo |= ~dp;
      bad |= (~(dp ^ dn) & exp) | ((dp | dn) & ~exp);
    end
    chk("pairs", {6'h0, exp}, {6'h0, (exp & hi & lo & ~bad) | (~exp & bad)});
    tick(1);
  endtask

  // Start or stop of pair 0 must show within three output periods
  task automatic wait_leg(input logic run);
    int k;
    for (k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      #1;
      if ((run && dp[0]) || (!run && !dp[0] && !dn[0])) break;
    end
    comparisons++;
    if (k == 6) begin
      n_fail++;
      $display("Error pair0_latency expected below 6 seen %0d", k);
      stop_test();
    end
    tick(1);
  endtask

  task automatic pwr_up(input logic [1:0] s);
    rst_b = 1'b0;
    pg = 1'b0;
    strap = s;
    pin_n = 2'h0;
    tick(3);
    rst_b = 1'b1;
    tick(3);
    chk("legs_off", 8'h00, {4'h0, dp, dn});
    chk("pll_en_off", 8'h00, {7'h0, pll_en});
    pg = 1'b1;
    tick(80);
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      pwr_up(STRAP[i]);
      chk("pll_en", {7'h0, MODE[i] != 2'h1}, {7'h0, pll_en});
      chk("high_bw", {7'h0, MODE[i] == 2'h3}, {7'h0, high_bw});
      chk("slew", 8'h03, {6'h0, slew});
      chk("amp", 8'h02, {6'h0, amp});
      obs(2'h3);
      host.rd(CFOG_IDX_MODE, d);
      chk("mode_rb", {MODE[i], 1'b0, MODE[i], 3'h2}, d & 8'hDB);
    end
    for (int i = 0; i < 5; i++) begin
      host.wr(CFOG_SMB_ADDR, CFOG_IDX_ENABLE, {6'h0, ROWS[i][5:4]}, a);
      chk("ack", 8'h00, {7'h0, a});
      pin_n = ROWS[i][3:2];
      tick(16);
      obs(ROWS[i][1:0]);
    end
    host.wr(CFOG_SMB_ADDR, CFOG_IDX_ENABLE, 8'h03, a);
    pin_n = 2'h0;
    for (int i = 0; i < 3; i++) begin
      host.wr(CFOG_SMB_ADDR, CFOG_IDX_MODE, MDATA[i], a);
      tick(8);
      chk("high_bw", {7'h0, MDATA[i][4:3] == 2'h3}, {7'h0, high_bw});
      chk("pll_en", {7'h0, MDATA[i][4:3] != 2'h1}, {7'h0, pll_en});
      chk("amp", {6'h0, MDATA[i][1:0]}, {6'h0, amp});
      obs(2'h3);
    end
    host.wr(CFOG_SMB_ADDR, CFOG_IDX_SLEW, 8'h01, a);
    tick(4);
    chk("slew", 8'h01, {6'h0, slew});
    host.wr(7'h6C, CFOG_IDX_ENABLE, 8'h00, a);
    chk("ack_other", 8'h01, {7'h0, a});
    obs(2'h3);
    pin_n[0] = 1'b1;
    wait_leg(1'b0);
    obs(2'h2);
    pin_n[0] = 1'b0;
    wait_leg(1'b1);
    pg = 1'b0;
    tick(4);
    chk("legs_off", 8'h00, {4'h0, dp, dn});
    chk("pll_en_off", 8'h00, {7'h0, pll_en});
    strap = 2'h0;
    host.lock_cyc = 5000;
    pg = 1'b1;
    tick(60);
    obs(2'h0);
    tick(TMO);
    obs(2'h3);
    host.rd(CFOG_IDX_MODE, d);
    chk("mode_rb", 8'hC0, d & 8'hC0);
    stop_test();
  end
endmodule
